// File: logic/spi_div_pkg.sv
// package: register map, field layout and types for the serial clock divider and data path
`default_nettype none
package spi_div_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0]  CTRL_IDX = 8'hA1;
  localparam logic [7:0]  CKR_IDX  = 8'hA2;
  localparam logic [7:0]  DATA_IDX = 8'hA3;
  localparam logic [11:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [11:0] CKR_ADDR  = {2'h0, CKR_IDX, 2'h0};
  localparam logic [11:0] DATA_ADDR = {2'h0, DATA_IDX, 2'h0};
  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int         CTRL_MASTER_BIT = 0;
  localparam int         CTRL_BUSY_BIT   = 1;
  localparam logic [7:0] DATA_RESET      = 8'h00;
  localparam logic [7:0] CKR_RESET       = 8'h00;
  localparam logic [2:0] LAST_BIT        = 3'h7;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_SHIFT} xfer_state_t;
  typedef struct packed {
    logic sck;
    logic mosi;
  } serial_out_t;
endpackage
`default_nettype wire

// File: logic/spi_clock_divider_data.sv
// design: apb slave with master-mode sck divider and byte data path
//
// The implementer's own choice: the APB slave port.
`default_nettype none
// What this block does
// - master sck equals core_clock divided by two times divider value plus one.
// - writing the data register loads the byte into the transmit buffer.
// - in master mode a data write while idle also starts a transfer.
// - reading the data register returns the receive buffer.
module spi_clock_divider_data (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // serial link
  output var  logic        sck,
  output var  logic        mosi,
  input  wire logic        miso,
  // status
  output var  logic        busy
);
  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire logic setup_ph  = psel & ~penable;
  wire logic access_ph = psel & penable & pready;
  wire logic hit_ctrl  = (paddr == spi_div_pkg::CTRL_ADDR);
  wire logic hit_ckr   = (paddr == spi_div_pkg::CKR_ADDR);
  wire logic hit_data  = (paddr == spi_div_pkg::DATA_ADDR);
  wire logic mapped    = hit_ctrl | hit_ckr | hit_data;
  wire logic wr_ctrl   = access_ph & pwrite & hit_ctrl;
  wire logic wr_ckr    = access_ph & pwrite & hit_ckr;
  wire logic wr_data   = access_ph & pwrite & hit_data;

  logic [7:0]                ckr_q;
  logic                      master_q;
  logic [7:0]                tx_buf_q;
  logic [7:0]                rx_buf_q;
  logic [7:0]                tx_sh_q;
  logic [7:0]                rx_sh_q;
  logic [7:0]                div_cnt_q;
  logic [2:0]                bit_cnt_q;
  spi_div_pkg::xfer_state_t  state_q;
  spi_div_pkg::serial_out_t  ser_q;
  logic [2:0]                miso_sync_q;
  logic                      miso_q;
  logic                      busy_q;

  wire logic shifting  = (state_q == spi_div_pkg::ST_SHIFT);
  wire logic start     = wr_data & master_q & ~shifting;
  wire logic half_done = shifting & (div_cnt_q == ckr_q);
  wire logic rise_edge = half_done & ~ser_q.sck;
  wire logic fall_edge = half_done & ser_q.sck;
  wire logic last_fall = fall_edge & (bit_cnt_q == spi_div_pkg::LAST_BIT);

  wire logic [31:0] ctrl_word = {30'h0, shifting, master_q};
  wire logic [31:0] rd_word   = hit_data ? {24'h0, rx_buf_q} :
                                hit_ckr  ? {24'h0, ckr_q} :
                                hit_ctrl ? ctrl_word : 32'h0;

  // ---------------------------------------------------------------
  // apb answer: registered, zero wait in the access phase
  // ---------------------------------------------------------------
  // pready from a flop costs nothing in the access phase and never glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~mapped;
      if (setup_ph && !pwrite) begin
        prdata <= rd_word;
      end
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  // unmapped writes miss every decode, so they change nothing here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ckr_q    <= spi_div_pkg::CKR_RESET;
      master_q <= 1'b0;
      tx_buf_q <= spi_div_pkg::DATA_RESET;
    end else begin
      if (wr_ckr) begin
        ckr_q <= pwdata[7:0];
      end
      if (wr_ctrl) begin
        master_q <= pwdata[spi_div_pkg::CTRL_MASTER_BIT];
      end
      if (wr_data) begin
        tx_buf_q <= pwdata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // miso synchroniser: change accepted when stages two and three agree
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miso_sync_q <= 3'h0;
      miso_q      <= 1'b0;
    end else begin
      miso_sync_q <= {miso_sync_q[1:0], miso};
      if (miso_sync_q[1] == miso_sync_q[2]) begin
        miso_q <= miso_sync_q[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // transfer engine, mode 0, msb first
  // ---------------------------------------------------------------
  // the synchroniser delays miso by four cycles, so divider values
  // below four sample a stale miso bit: a limit of the three-flop filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= spi_div_pkg::ST_IDLE;
      ser_q     <= '0;
      div_cnt_q <= 8'h00;
      bit_cnt_q <= 3'h0;
      tx_sh_q   <= 8'h00;
      rx_sh_q   <= 8'h00;
      rx_buf_q  <= spi_div_pkg::DATA_RESET;
      busy_q    <= 1'b0;
    end else begin
      unique case (state_q)
        spi_div_pkg::ST_IDLE: begin
          if (start) begin
            state_q    <= spi_div_pkg::ST_SHIFT;
            busy_q     <= 1'b1;
            tx_sh_q    <= pwdata[7:0];
            ser_q.mosi <= pwdata[7];
            div_cnt_q  <= 8'h00;
            bit_cnt_q  <= 3'h0;
          end
        end
        spi_div_pkg::ST_SHIFT: begin
          div_cnt_q <= half_done ? 8'h00 : div_cnt_q + 8'h01;
          if (half_done) begin
            ser_q.sck <= ~ser_q.sck;
          end
          if (rise_edge) begin
            rx_sh_q <= {rx_sh_q[6:0], miso_q};
          end
          if (last_fall) begin
            rx_buf_q <= rx_sh_q;
            state_q  <= spi_div_pkg::ST_IDLE;
            busy_q   <= 1'b0;
          end else if (fall_edge) begin
            tx_sh_q    <= {tx_sh_q[6:0], 1'b0};
            ser_q.mosi <= tx_sh_q[6];
            bit_cnt_q  <= bit_cnt_q + 3'h1;
          end
        end
      endcase
    end
  end

  assign sck  = ser_q.sck;
  assign mosi = ser_q.mosi;
  assign busy = busy_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_sck_toggle_due: assert property (@(posedge pclk) disable iff (!presetn)
    half_done |=> $changed(ser_q.sck))
    else $error("sck did not toggle at divider terminal count");

  a_sck_hold_between: assert property (@(posedge pclk) disable iff (!presetn)
    (shifting && !half_done && $stable(ckr_q)) |=> $stable(ser_q.sck) && div_cnt_q == $past(div_cnt_q) + 8'h01)
    else $error("sck moved before divider terminal count");

  a_tx_buffer_load: assert property (@(posedge pclk) disable iff (!presetn)
    wr_data |=> tx_buf_q == $past(pwdata[7:0]))
    else $error("data write did not load transmit buffer");

  a_master_start: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_data && master_q && !shifting) |=> shifting && !ser_q.sck && mosi == $past(pwdata[7]))
    else $error("master data write did not start a transfer");

  a_slave_no_start: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_data && !master_q && !shifting) |=> !shifting)
    else $error("data write outside master mode started a transfer");

  a_read_rx_buffer: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && hit_data) |=> prdata == {24'h0, $past(rx_buf_q)} && pready)
    else $error("data read did not return receive buffer");

  a_rx_capture_end: assert property (@(posedge pclk) disable iff (!presetn)
    last_fall |=> !shifting && rx_buf_q == $past(rx_sh_q) && !ser_q.sck)
    else $error("receive buffer not updated at end of eighth bit");

  a_bit_count_range: assert property (@(posedge pclk) disable iff (!presetn)
    (fall_edge && !last_fall) |=> shifting && bit_cnt_q == $past(bit_cnt_q) + 3'h1)
    else $error("bit counter did not advance on falling sck");

  a_busy_mirrors_state: assert property (@(posedge pclk) disable iff (!presetn)
    busy == shifting)
    else $error("busy output does not follow the transfer state");

  a_idle_sck_low: assert property (@(posedge pclk) disable iff (!presetn)
    !shifting |-> !ser_q.sck)
    else $error("sck not low while idle");

  a_start_clears_counts: assert property (@(posedge pclk) disable iff (!presetn)
    start |=> div_cnt_q == 8'h00 && bit_cnt_q == 3'h0)
    else $error("transfer start did not clear the counters");

  a_busy_write_no_restart: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_data && shifting && !fall_edge) |=> bit_cnt_q == $past(bit_cnt_q))
    else $error("data write while busy restarted the transfer");

  a_mosi_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (shifting && !fall_edge) |=> $stable(ser_q.mosi))
    else $error("mosi changed away from a falling sck");

  a_tx_shift_next: assert property (@(posedge pclk) disable iff (!presetn)
    (fall_edge && !last_fall) |=> ser_q.mosi == $past(tx_sh_q[6]))
    else $error("mosi did not present the next transmit bit");

  a_rx_sample_rise: assert property (@(posedge pclk) disable iff (!presetn)
    rise_edge |=> rx_sh_q == {$past(rx_sh_q[6:0]), $past(miso_q)})
    else $error("miso not captured on rising sck");

  a_rx_hold_mid: assert property (@(posedge pclk) disable iff (!presetn)
    (shifting && !last_fall) |=> $stable(rx_buf_q))
    else $error("receive buffer changed before the eighth bit");

  // ---------------------------------------------------------------
  // bus answer assertions
  // ---------------------------------------------------------------
  a_pready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph |=> pready)
    else $error("pready missing after setup phase");

  a_pready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  a_pready_needs_setup: assert property (@(posedge pclk) disable iff (!presetn)
    !setup_ph |=> !pready)
    else $error("pready raised without a setup phase");

  a_slverr_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && !mapped) |=> pslverr && pready)
    else $error("unmapped access did not report an error");

  a_slverr_mapped_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && mapped) |=> !pslverr)
    else $error("mapped access reported an error");

  a_prdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(setup_ph && !pwrite) |=> $stable(prdata))
    else $error("read data changed outside a read");

  a_read_ckr_value: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && hit_ckr) |=> prdata == {24'h0, $past(ckr_q)})
    else $error("divider read returned a wrong value");

  a_read_ctrl_value: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && hit_ctrl) |=> prdata == {30'h0, $past(shifting), $past(master_q)})
    else $error("control read returned a wrong value");

  a_read_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && !mapped) |=> prdata == 32'h0)
    else $error("unmapped read returned nonzero data");

  // ---------------------------------------------------------------
  // register and synchroniser assertions
  // ---------------------------------------------------------------
  a_ckr_write_load: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ckr |=> ckr_q == $past(pwdata[7:0]))
    else $error("divider write did not load the divider");

  a_master_write_load: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> master_q == $past(pwdata[spi_div_pkg::CTRL_MASTER_BIT]))
    else $error("control write did not load the master bit");

  a_bad_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (access_ph && pwrite && !mapped) |=> $stable(ckr_q) && $stable(master_q) && $stable(tx_buf_q))
    else $error("unmapped write changed a register");

  a_miso_accept: assert property (@(posedge pclk) disable iff (!presetn)
    (miso_sync_q[1] == miso_sync_q[2]) |=> miso_q == $past(miso_sync_q[2]))
    else $error("agreeing miso stages were not accepted");

  a_miso_reject: assert property (@(posedge pclk) disable iff (!presetn)
    (miso_sync_q[1] != miso_sync_q[2]) |=> $stable(miso_q))
    else $error("disagreeing miso stages changed the input");
endmodule
`default_nettype wire

// File: sim/spi_slave_model.sv
// partner: mode 0 serial peripheral returning a preloaded byte
`default_nettype none
module spi_slave_model (
  // serial link
  input  wire logic       sck,
  input  wire logic       mosi,
  output var  logic       miso,
  // bench side
  input  wire logic       load,
  input  wire logic [7:0] tx_byte,
  output var  logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] shift_q;
  initial begin
    shift_q = 8'h00;
    rx_byte = 8'h00;
  end
  always @(posedge load) shift_q = tx_byte;
  always_comb miso = shift_q[7];
  // capture on rising sck, msb first
  always @(posedge sck) rx_byte = {rx_byte[6:0], mosi};
  // shift on falling sck: miso then has a half period to pass the sync flops
  always @(negedge sck) shift_q = {shift_q[6:0], 1'b0};
endmodule
`default_nettype wire

// File: sim/spi_clock_divider_data_bench.sv
// bench: apb driver, expectation queue and serial partner
`default_nettype none
module spi_clock_divider_data_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sck, mosi, miso, busy, load;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, n, n_mismatch, total_checks;
  logic [7:0]  seed, div, tx, sb, slave_tx, slave_rx;
  logic [32:0] exp_q[$];
  logic [7:0]  byte_q[$];
  longint      last_rise;
  spi_clock_divider_data u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck(sck), .mosi(mosi), .miso(miso), .busy(busy));
  spi_slave_model u_slave (.sck(sck), .mosi(mosi), .miso(miso), .load(load),
    .tx_byte(slave_tx), .rx_byte(slave_rx));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_count(input logic [31:0] got, input logic [31:0] exp);
    cmp({1'b0, got}, {1'b0, exp});
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp({25'h0, got}, {25'h0, exp});
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one transfer; expectation is {pslverr, read data or zero}
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    int k;
    exp_q.push_back(e);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin n_mismatch++; stop_test(); end
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) if (psel && penable && pready) cmp({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
  // sck period between rising edges inside one transfer
  always @(posedge sck) begin
    if (last_rise != 0) cmp_count(32'($time - last_rise), 32'((div + 1) * 10));
    last_rise = $time;
  end
  // link result: the slave's captured byte is checked as busy drops
  always @(negedge busy) if (presetn === 1'b1) cmp_byte(slave_rx, byte_q.pop_front());
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    load = 1'b0; slave_tx = 8'h00; seed = 8'h2D; div = 8'h00; last_rise = 0; sb = 8'h00;
    n_mismatch = 0; total_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, spi_div_pkg::DATA_ADDR, 32'h0, 33'h0);
    apb(1'b0, spi_div_pkg::CKR_ADDR, 32'h0, 33'h0);
    apb(1'b0, 12'hFFC, 32'h0, {1'b1, 32'h0});
    apb(1'b1, spi_div_pkg::CTRL_ADDR, 32'h1, 33'h0);
    $display("test reset and map done");
    // divider of at least 4 keeps miso ahead of the three-flop sync
    for (int i = 0; i < 2; i++) begin
      div = (i == 0) ? 8'h04 : 8'h07;
      seed = lfsr(seed); tx = seed;
      seed = lfsr(seed); sb = seed;
      slave_tx <= sb; load <= 1'b1;
      apb(1'b1, spi_div_pkg::CKR_ADDR, {24'h0, div}, 33'h0);
      load <= 1'b0; last_rise = 0;
      byte_q.push_back(tx);
      apb(1'b1, spi_div_pkg::DATA_ADDR, {24'h0, tx}, 33'h0);
      n = 1;
      #1;
      while (busy === 1'b1 && n < 5000) begin
        @(posedge pclk);
        #1;
        n++;
      end
      if (n >= 5000) begin n_mismatch++; stop_test(); end
      @(posedge pclk);
      cmp_count(n, 32'(16 * (div + 1)));
      apb(1'b0, spi_div_pkg::DATA_ADDR, 32'h0, {25'h0, sb});
      $display("test transfer div=%0d done", div);
    end
    apb(1'b1, spi_div_pkg::CTRL_ADDR, 32'h0, 33'h0);
    apb(1'b1, spi_div_pkg::DATA_ADDR, 32'hA5, 33'h0);
    cmp_count({31'h0, busy}, 32'h0);
    apb(1'b0, spi_div_pkg::DATA_ADDR, 32'h0, {25'h0, sb});
    $display("test slave mode write done");
    // reset in mid-frame must stop the engine and restore every register
    apb(1'b1, spi_div_pkg::CTRL_ADDR, 32'h1, 33'h0);
    last_rise = 0;
    apb(1'b1, spi_div_pkg::DATA_ADDR, 32'h3C, 33'h0);
    apb(1'b0, spi_div_pkg::CTRL_ADDR, 32'h0, 33'h3);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmp_count({31'h0, busy}, 32'h0);
    apb(1'b0, spi_div_pkg::DATA_ADDR, 32'h0, 33'h0);
    apb(1'b0, spi_div_pkg::CKR_ADDR, 32'h0, 33'h0);
    apb(1'b0, spi_div_pkg::CTRL_ADDR, 32'h0, 33'h0);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule
`default_nettype wire
